// file: hdl/lec_ldo_enable_config_regs.sv
// configuration, enable and discharge control of the second low-dropout regulator
// ------------------------------------------------------------
// Notes on behaviour
// RULE1: three-bit sequence slot in bits 7..5 is read-only to software.
// RULE2: slot 000 keeps regulator off; 001 enables it while supply rail present.
// RULE3: slots 010, 011, 100 enable at 0%, 25%, 50% of boot delay.
// RULE4: slots 101, 110 stay off; 111 hands over to software after full delay.
// RULE5: discharge bit 1 discharges in forced power-down and while enable is low.
// RULE6: discharge bit 0 discharges only in forced power-down or shutdown/off, not on disable.
// RULE7: software enable selection acts only while slot equals 111.
// RULE8: selection 00 disables without discharge except forced/shutdown/off; 01 enables.
// RULE9: selection 10 follows input zero, selection 11 follows input one.
// RULE10: mode bit 0 regulates; 1 makes the pass device a plain switch.
// RULE11: mode bit is latched internally and changes only while regulator disabled.
// ------------------------------------------------------------
module lec_ldo_enable_config_regs
    import lec_pkg::*;
#(
    parameter logic [4:0] VCODE_RESET = LEC_VCODE_RST
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire lec_regreq_t regReq,
    output logic [7:0]       regRdData,
    input  wire logic [2:0]  sequenceSlotStrap,
    input  wire logic        supplyPresent,
    input  wire logic        multiPurposeInputZero,
    input  wire logic        multiPurposeInputOne,
    input  wire lec_boot_t   bootProgress,
    input  wire lec_pwr_t    powerState,
    output logic             regulatorEnable,
    output logic             outputDischarge,
    output logic             switchModeActive,
    output logic [4:0]       outputVoltageCode
);

    typedef struct packed {
        lec_cfg_t   cfg;
        logic [4:0] vcode;
        logic       slotValid;
        logic       modeLatched;
        logic       enable;
        logic       discharge;
        logic [7:0] rdData;
    } lec_state_t;

    lec_state_t st_r;
    lec_state_t st_nxt;
    logic [2:0] pinSync;
    logic       supplySync;
    logic       in0Sync;
    logic       in1Sync;
    logic       forceOff;
    logic       quietOff;
    logic       enableWant;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    lec_sync #(
        .WIDTH   (3)
    ) u_pinSync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn ({supplyPresent, multiPurposeInputOne, multiPurposeInputZero}),
        .syncOut (pinSync)
    );

    assign supplySync = pinSync[2];
    assign in1Sync    = pinSync[1];
    assign in0Sync    = pinSync[0];
    assign forceOff   = powerState.forcedPowerDown | powerState.shutdownOrOff;
    // selection 00 under software control disables without discharge
    assign quietOff   = (st_r.cfg.slot == LEC_SLOT_SOFT) && (st_r.cfg.sel == LEC_SEL_OFF); // RULE8

    // ------------------------------------------------------------
    // enable decode
    // ------------------------------------------------------------
    function automatic logic lec_soft_enable(lec_sel_t sel, logic in0, logic in1);
        logic en;
        en = 1'b0;
        unique case (sel)
            LEC_SEL_OFF: en = 1'b0;                 // RULE8
            LEC_SEL_ON:  en = 1'b1;                 // RULE8
            LEC_SEL_IN0: en = in0;                  // RULE9
            LEC_SEL_IN1: en = in1;                  // RULE9
        endcase
        return en;
    endfunction

    always_comb
    begin
        enableWant = 1'b0;
        unique case (st_r.cfg.slot)
            LEC_SLOT_OFF:    enableWant = 1'b0;                 // RULE2
            LEC_SLOT_SUPPLY: enableWant = supplySync;           // RULE2
            LEC_SLOT_BOOT0:  enableWant = bootProgress.started; // RULE3
            LEC_SLOT_BOOT25: enableWant = bootProgress.quarter; // RULE3
            LEC_SLOT_BOOT50: enableWant = bootProgress.half;    // RULE3
            LEC_SLOT_OFF5:   enableWant = 1'b0;                 // RULE4
            LEC_SLOT_OFF6:   enableWant = 1'b0;                 // RULE4
            // selection only consulted in this arm
            LEC_SLOT_SOFT:   enableWant = bootProgress.done
                                 & lec_soft_enable(st_r.cfg.sel, in0Sync, in1Sync); // RULE7
        endcase
        // strap not yet captured, or device forced down: keep off
        if (!st_r.slotValid || forceOff)
        begin
            enableWant = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // strap is caught on the first edge after reset release
        if (!st_r.slotValid)
        begin
            st_nxt.cfg.slot  = lec_slot_t'(sequenceSlotStrap);
            st_nxt.slotValid = 1'b1;
        end
        if (regReq.wrEn && regReq.addr == LEC_ADDR_CONFIG)
        begin
            // slot and reserved bit are not writable
            st_nxt.cfg.discharge = regReq.wrData[LEC_DSC_BIT];                         // RULE1
            st_nxt.cfg.sel       = lec_sel_t'(regReq.wrData[LEC_SEL_MSB:LEC_SEL_LSB]);
            st_nxt.cfg.mode      = regReq.wrData[LEC_MODE_BIT];
        end
        if (regReq.wrEn && regReq.addr == LEC_ADDR_VOLTAGE)
        begin
            st_nxt.vcode = regReq.wrData[LEC_VCODE_W-1:0];
        end
        st_nxt.enable = enableWant;
        // latched copy follows the register only while disabled
        if (!st_r.enable)
        begin
            st_nxt.modeLatched = st_r.cfg.mode;                                        // RULE11
        end
        // option bit selects whether a normal disable also discharges
        st_nxt.discharge = forceOff                                   // RULE6
                         | (st_r.cfg.discharge & ~enableWant & ~quietOff); // RULE5 RULE8
        st_nxt.rdData = LEC_RD_IDLE;
        if (regReq.rdEn)
        begin
            if (regReq.addr == LEC_ADDR_CONFIG)
            begin
                st_nxt.rdData = {st_r.cfg.slot, 1'b0, st_r.cfg.discharge,
                                 st_r.cfg.sel, st_r.cfg.mode};
            end
            else if (regReq.addr == LEC_ADDR_VOLTAGE)
            begin
                st_nxt.rdData = {3'h0, st_r.vcode};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r                <= '0;
            st_r.cfg.discharge  <= LEC_DSC_RST;
            st_r.cfg.sel        <= lec_sel_t'(LEC_SEL_RST);
            st_r.cfg.mode       <= LEC_MODE_RST;
            st_r.vcode          <= VCODE_RESET;
            st_r.modeLatched    <= LEC_MODE_RST;
            st_r.rdData         <= LEC_RD_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign regRdData         = st_r.rdData;
    assign regulatorEnable   = st_r.enable;
    assign outputDischarge   = st_r.discharge;
    assign switchModeActive  = st_r.modeLatched;    // RULE10
    assign outputVoltageCode = st_r.vcode;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_slot_fixed: assert property (st_r.slotValid |=> $stable(st_r.cfg.slot)) // RULE1
        else $error("sequence slot changed after capture");
    chk_slot_off: assert property (st_r.cfg.slot == LEC_SLOT_OFF |=> !regulatorEnable) // RULE2
        else $error("slot 000 but regulator enabled");
    chk_slot_quarter: assert property ( // RULE3
        st_r.slotValid && st_r.cfg.slot == LEC_SLOT_BOOT25 && !forceOff
        |=> regulatorEnable == $past(bootProgress.quarter))
        else $error("slot 011 enable not tied to quarter of boot delay");
    chk_slot_parked: assert property ( // RULE4
        st_r.cfg.slot inside {LEC_SLOT_OFF5, LEC_SLOT_OFF6} |=> !regulatorEnable [*2])
        else $error("slot 101/110 but regulator enabled");
    chk_dsc_follow: assert property ( // RULE5
        st_r.cfg.discharge && !forceOff && !quietOff |=> outputDischarge == !regulatorEnable)
        else $error("discharge does not follow low enable");
    chk_sel_quiet: assert property ( // RULE8
        quietOff && !forceOff |=> !outputDischarge)
        else $error("selection 00 discharged outside forced states");
    chk_dsc_quiet: assert property ( // RULE6
        !st_r.cfg.discharge |=> outputDischarge == $past(forceOff))
        else $error("discharge outside forced power-down");
    chk_sel_ignored: assert property ( // RULE7
        st_r.cfg.slot == LEC_SLOT_BOOT0 && st_r.cfg.sel == LEC_SEL_ON
        && !bootProgress.started |=> !regulatorEnable)
        else $error("software selection acted outside slot 111");
    chk_sel_off: assert property ( // RULE8
        st_r.cfg.slot == LEC_SLOT_SOFT && st_r.cfg.sel == LEC_SEL_OFF |=> !regulatorEnable)
        else $error("selection 00 left regulator enabled");
    chk_sel_input: assert property ( // RULE9
        st_r.slotValid && st_r.cfg.slot == LEC_SLOT_SOFT && st_r.cfg.sel == LEC_SEL_IN1
        && bootProgress.done && !forceOff |=> regulatorEnable == $past(in1Sync))
        else $error("selection 11 does not follow input one");
    chk_mode_apply: assert property (!regulatorEnable |=> switchModeActive == $past(st_r.cfg.mode)) // RULE10
        else $error("mode not taken while disabled");
    chk_mode_hold: assert property (regulatorEnable |=> $stable(switchModeActive)) // RULE11
        else $error("mode changed while enabled");

    cov_soft_in0: cover property (st_r.cfg.slot == LEC_SLOT_SOFT && st_r.cfg.sel == LEC_SEL_IN0
                                  ##1 regulatorEnable);
    cov_boot_half: cover property (st_r.cfg.slot == LEC_SLOT_BOOT50 ##1 regulatorEnable);
    cov_dsc_fall: cover property (regulatorEnable ##1 !regulatorEnable && outputDischarge);
    cov_mode_switch: cover property ($rose(switchModeActive));

endmodule

// file: hdl/lec_pkg.sv
// shared types and constants for the second regulator's configuration registers
package lec_pkg;

    // ------------------------------------------------------------
    // register offsets on the serial register port
    // ------------------------------------------------------------
    localparam logic [7:0] LEC_ADDR_CONFIG  = 8'h14;
    localparam logic [7:0] LEC_ADDR_VOLTAGE = 8'h15;

    // ------------------------------------------------------------
    // field layout and values after reset
    // ------------------------------------------------------------
    localparam int         LEC_SLOT_MSB     = 7;
    localparam int         LEC_SLOT_LSB     = 5;
    localparam int         LEC_RFU_BIT      = 4;
    localparam int         LEC_DSC_BIT      = 3;
    localparam int         LEC_SEL_MSB      = 2;
    localparam int         LEC_SEL_LSB      = 1;
    localparam int         LEC_MODE_BIT     = 0;
    localparam int         LEC_VCODE_W      = 5;
    localparam logic       LEC_DSC_RST      = 1'h0;
    localparam logic [1:0] LEC_SEL_RST      = 2'h0;
    localparam logic       LEC_MODE_RST     = 1'h0;
    localparam logic [4:0] LEC_VCODE_RST    = 5'h00;
    localparam logic [7:0] LEC_RD_IDLE      = 8'h00;
    localparam int         LEC_SYNC_STAGES  = 2;

    typedef enum logic [2:0] {
        LEC_SLOT_OFF    = 3'b000,
        LEC_SLOT_SUPPLY = 3'b001,
        LEC_SLOT_BOOT0  = 3'b010,
        LEC_SLOT_BOOT25 = 3'b011,
        LEC_SLOT_BOOT50 = 3'b100,
        LEC_SLOT_OFF5   = 3'b101,
        LEC_SLOT_OFF6   = 3'b110,
        LEC_SLOT_SOFT   = 3'b111
    } lec_slot_t;

    typedef enum logic [1:0] {
        LEC_SEL_OFF = 2'b00,
        LEC_SEL_ON  = 2'b01,
        LEC_SEL_IN0 = 2'b10,
        LEC_SEL_IN1 = 2'b11
    } lec_sel_t;

    typedef struct packed {
        lec_slot_t  slot;
        logic       rfu;
        logic       discharge;
        lec_sel_t   sel;
        logic       mode;
    } lec_cfg_t;

    // progress flags of the boot delay timer, each a level once reached
    typedef struct packed {
        logic started;
        logic quarter;
        logic half;
        logic done;
    } lec_boot_t;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } lec_regreq_t;

    typedef struct packed {
        logic forcedPowerDown;
        logic shutdownOrOff;
    } lec_pwr_t;

endpackage

// file: hdl/lec_sync.sv
// two-stage synchroniser for inputs arriving from outside the clock domain
module lec_sync
    import lec_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    // refused at elaboration, before any process runs
    if (WIDTH < 1)
    begin : g_width_check
        $error("lec_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } lec_sync_state_t;

    lec_sync_state_t st_r;
    lec_sync_state_t st_nxt;

    // stage1 feeds stage2 only
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.stage1 = asyncIn;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign syncOut = st_r.stage2;

endmodule

// file: testbench/test_ldo_enable_config_regs.sv
// self-checking bench for the second regulator's configuration registers
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end

module test_ldo_enable_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import lec_pkg::*;

    logic        clk;
    logic        rst_n;
    lec_regreq_t regReq;
    logic [7:0]  regRdData;
    logic [2:0]  sequenceSlotStrap;
    logic        supplyPresent;
    logic        multiPurposeInputZero;
    logic        multiPurposeInputOne;
    lec_boot_t   bootProgress;
    lec_pwr_t    powerState;
    logic        regulatorEnable;
    logic        outputDischarge;
    logic        switchModeActive;
    logic [4:0]  outputVoltageCode;
    int          num_errors;
    int          compares;
    logic [7:0]  rdv;

    lec_ldo_enable_config_regs dut_u (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .regReq                (regReq),
        .regRdData             (regRdData),
        .sequenceSlotStrap     (sequenceSlotStrap),
        .supplyPresent         (supplyPresent),
        .multiPurposeInputZero (multiPurposeInputZero),
        .multiPurposeInputOne  (multiPurposeInputOne),
        .bootProgress          (bootProgress),
        .powerState            (powerState),
        .regulatorEnable       (regulatorEnable),
        .outputDischarge       (outputDischarge),
        .switchModeActive      (switchModeActive),
        .outputVoltageCode     (outputVoltageCode)
    );

    // ------------------------------------------------------------
    // clock, shared tasks
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // strap is only captured after a reset, so every slot needs its own reset
    task automatic do_reset(input logic [2:0] s);
        @(negedge clk);
        rst_n = 1'b0;
        sequenceSlotStrap = s;
        regReq = '0;
        settle(8);
        rst_n = 1'b1;
        settle(2);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regReq = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        regReq.wrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regReq = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        regReq.rdEn = 1'b0;
        d = regRdData;
    endtask

    function automatic logic exp_en(int s, int st, logic sup, logic sw);
        case (s)
            1:       return sup;
            2:       return st >= 1;
            3:       return st >= 2;
            4:       return st >= 3;
            7:       return (st >= 4) && sw;
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_regs();
        do_reset(3'h7);
        `CHK(outputVoltageCode, 5'h00, "voltage reset")
        wr(8'h14, 8'hFF);
        rd(8'h14, rdv);
        `CHK(rdv, 8'hEF, "config write all ones")
        settle(1);
        `CHK(regRdData, 8'h00, "read data not released")
        wr(8'h14, 8'h00);
        wr(8'h16, 8'hFF);
        rd(8'h14, rdv);
        `CHK(rdv, 8'hE0, "slot field changed by write")
        wr(8'h15, 8'hFF);
        rd(8'h15, rdv);
        `CHK(rdv, 8'h1F, "voltage readback")
        `CHK(outputVoltageCode, 5'h1F, "voltage output")
        rd(8'h16, rdv);
        `CHK(rdv, 8'h00, "unmapped read")
    endtask

    task automatic test_slots();
        for (int s = 0; s < 8; s++)
        begin
            do_reset(3'(s));
            rd(8'h14, rdv);
            `CHK(rdv, {3'(s), 5'h00}, "config reset value")
            for (int st = 0; st < 5; st++)
            begin
                bootProgress = '{st >= 1, st >= 2, st >= 3, st >= 4};
                settle(4);
                `CHK(regulatorEnable, exp_en(s, st, 1'b1, 1'b0), "boot stage enable")
            end
            wr(8'h14, 8'h02);
            supplyPresent = 1'b0;
            settle(5);
            `CHK(regulatorEnable, exp_en(s, 4, 1'b0, 1'b1), "slot enable")
            `CHK(regulatorEnable, exp_en(s, 4, 1'b0, 1'b1), "software handover")
            supplyPresent = 1'b1;
            bootProgress = '0;
        end
    endtask

    task automatic test_select();
        logic e;
        do_reset(3'h7);
        bootProgress = '1;
        for (int sel = 0; sel < 4; sel++)
            for (int m = 0; m < 4; m++)
            begin
                wr(8'h14, {5'h00, 2'(sel), 1'b0});
                multiPurposeInputZero = m[0];
                multiPurposeInputOne = m[1];
                settle(5);
                e = (sel == 1) || (sel == 2 && m[0]) || (sel == 3 && m[1]);
                `CHK(regulatorEnable, e, "selection enable")
                `CHK(outputDischarge, 1'b0, "discharge with option clear")
            end
        wr(8'h14, 8'h02);
        powerState.forcedPowerDown = 1'b1;
        settle(3);
        `CHK(regulatorEnable, 1'b0, "forced power-down enable")
        `CHK(outputDischarge, 1'b1, "forced power-down discharge")
        powerState = '{1'b0, 1'b1};
        wr(8'h14, 8'h00);
        settle(3);
        `CHK(outputDischarge, 1'b1, "shutdown discharge")
        powerState = '0;
        bootProgress = '0;
        do_reset(3'h2);
        wr(8'h14, 8'h02);
        settle(3);
        `CHK(regulatorEnable, 1'b0, "selection acted off slot 111")
        wr(8'h14, 8'h00);
        bootProgress = '1;
        settle(4);
        `CHK(regulatorEnable, 1'b1, "selection ignored off slot 111")
    endtask

    task automatic test_discharge();
        do_reset(3'h7);
        bootProgress = '1;
        multiPurposeInputZero = 1'b0;
        wr(8'h14, 8'h08);
        settle(3);
        `CHK(outputDischarge, 1'b0, "discharge with selection 00")
        wr(8'h14, 8'h0A);
        settle(3);
        `CHK(regulatorEnable, 1'b1, "enabled with option set")
        `CHK(outputDischarge, 1'b0, "discharge while enabled")
        wr(8'h14, 8'h0C);
        settle(5);
        `CHK(regulatorEnable, 1'b0, "input zero low but enabled")
        `CHK(outputDischarge, 1'b1, "no discharge after enable fell")
    endtask

    task automatic test_mode();
        do_reset(3'h7);
        bootProgress = '1;
        wr(8'h14, 8'h02);
        settle(3);
        wr(8'h14, 8'h03);
        settle(3);
        `CHK(switchModeActive, 1'b0, "mode changed while enabled")
        wr(8'h14, 8'h01);
        settle(3);
        `CHK(switchModeActive, 1'b1, "mode not taken while disabled")
        wr(8'h14, 8'h03);
        settle(3);
        wr(8'h14, 8'h02);
        settle(3);
        `CHK(switchModeActive, 1'b1, "mode not frozen while enabled")
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        num_errors = 0;
        compares = 0;
        rst_n = 1'b0;
        regReq = '0;
        sequenceSlotStrap = 3'h0;
        supplyPresent = 1'b1;
        multiPurposeInputZero = 1'b0;
        multiPurposeInputOne = 1'b0;
        bootProgress = '0;
        powerState = '0;
        test_regs();
        test_slots();
        test_select();
        test_discharge();
        test_mode();
        give_verdict();
    end

    // a hang counts as a mismatch and still reaches the verdict
    initial
    begin
        repeat (50000) @(posedge clk);
        num_errors++;
        $display("CHECK FAILED t=%0t run did not finish", $time);
        give_verdict();
    end
endmodule
